// [core/hbp_port.sv]
`timescale 1ns/1ps

// Overview of operation
// - Request bus, drive nothing until hold_grant seen true.
// - Cycle is address_state then data_state, repeated while ready false.
// - Master outputs hold through data_state, change entering address_state.
// - Slave adds fixed wait states; master adds none itself.
// - Slave write data latched on edge that raises ready output.
// - Master stays in data_state until slave_ready_input seen true.
// - Slave drives ready output and also samples slave_ready_input.
// - Ready output is registered on the device clock, no outside sync.
// - Double-rate clock divided by two sequences the bus machine.
// - Phase one of address_state begins on third edge after reset.
// - Long-word addresses with four active-low byte lane enables.
// - Data on disabled byte lanes is ignored in both roles.
// - Script fetches long-word aligned; data buffers any alignment.
// - Misaligned: head 3/2/1 bytes, then words, tail 4/3/2/1 bytes.
module hbp_port (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        reset_n_in,
  // Arbitration
  output logic                             bus_request_out,
  input  wire logic                        hold_grant_in,
  input  wire logic                        downstream_hold_request_in,
  output logic                             downstream_hold_grant_out,
  // Master bus outputs
  output logic [hbp_pkg::ADDR_W-1:2]       bus_addr_out,
  output logic [hbp_pkg::LANES-1:0]        byte_lane_enables_n_out,
  output logic                             bus_write_out,
  output logic                             addr_strobe_n_out,
  output logic                             bus_ctl_oe_out,
  // Data pins
  input  wire logic [hbp_pkg::DATA_W-1:0]  bus_data_in,
  output logic [hbp_pkg::DATA_W-1:0]       bus_data_out,
  output logic                             bus_data_oe_out,
  // Ready
  input  wire logic                        slave_ready_input_in,
  output logic                             ready_output_to_host_out,
  // Slave access from host
  input  wire logic                        slave_sel_n_in,
  input  wire logic                        slave_write_in,
  input  wire logic [hbp_pkg::SREG_W-1:2]  slave_addr_in,
  input  wire logic [hbp_pkg::LANES-1:0]   slave_be_n_in,
  // Core register port
  output logic [hbp_pkg::SREG_W-1:2]       reg_addr_out,
  output logic [hbp_pkg::DATA_W-1:0]       reg_wdata_out,
  output logic [hbp_pkg::LANES-1:0]        reg_be_out,
  output logic                             reg_we_out,
  input  wire logic [hbp_pkg::DATA_W-1:0]  reg_rdata_in,
  // Core transfer request
  input  wire logic                        xfer_start_in,
  input  wire logic                        xfer_write_in,
  input  wire logic                        xfer_script_in,
  input  wire logic [hbp_pkg::ADDR_W-1:0]  xfer_addr_in,
  input  wire logic [hbp_pkg::LEN_W-1:0]   xfer_len_in,
  input  wire logic [hbp_pkg::DATA_W-1:0]  xfer_wdata_in,
  output logic                             xfer_busy_out,
  output logic                             xfer_error_out,
  output logic                             xfer_wdata_take_out,
  output logic [hbp_pkg::DATA_W-1:0]       xfer_rdata_out,
  output logic [hbp_pkg::LANES-1:0]        xfer_rbe_out,
  output logic                             xfer_rvalid_out,
  output logic                             xfer_done_out
);

  hbp_pkg::hbp_state_t             state_q;
  logic                            phase_one;
  logic                            advance;
  logic [hbp_pkg::ADDR_W-1:0]      addr_q;
  logic [hbp_pkg::LEN_W-1:0]       remain_q;
  logic [1:0]                      wait_q;
  logic [2:0]                      beat_n;
  logic [hbp_pkg::LANES-1:0]       beat_be;

  // Lane mask for a beat starting at byte offset off and moving n bytes
  function automatic logic [3:0] lane_mask(input logic [1:0] off, input logic [2:0] n);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++)
      if ((3'(i) >= {1'b0, off}) && (3'(i) < ({1'b0, off} + n)))
        m[i] = 1'b1;
    return m;
  endfunction

  // Data with disabled lanes forced to zero
  function automatic logic [31:0] lane_gate(input logic [31:0] d, input logic [3:0] en);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++)
      if (en[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // ==========================================================
  // Half-rate phase sequencing
  // bus machine steps only at phase boundaries
  hbp_phase_gen u_phase (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .phase_one_out (phase_one),
    .advance_out   (advance)
  );

  // ==========================================================
  // Beat sizing
  // head bytes reach the boundary, then full words, short tail
  always_comb
  begin
    beat_n = 3'h4 - {1'b0, addr_q[1:0]};
    if ({13'h0, beat_n} > remain_q)
      beat_n = remain_q[2:0];
    beat_be = lane_mask(addr_q[1:0], beat_n);
  end

  // ==========================================================
  // Bus state machine
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      state_q <= hbp_pkg::ST_IDLE;
    else if (advance)
    begin
      unique case (state_q)
        hbp_pkg::ST_IDLE:
          if (!slave_sel_n_in && !bus_request_out)
            state_q <= hbp_pkg::ST_SWAIT;
          else if (xfer_busy_out && !xfer_error_out)
            state_q <= hbp_pkg::ST_REQ;
        hbp_pkg::ST_REQ:
          if (hold_grant_in)
            state_q <= hbp_pkg::ST_ADDR;
        hbp_pkg::ST_ADDR:
          state_q <= hbp_pkg::ST_DATA;
        // wait without limit for the slave
        hbp_pkg::ST_DATA:
          if (slave_ready_input_in)
            state_q <= ({3'h0, remain_q} == {3'h0, beat_n} + 19'h0) ? hbp_pkg::ST_IDLE
                                                                   : hbp_pkg::ST_ADDR;
        hbp_pkg::ST_SWAIT:
          if (wait_q == hbp_pkg::SLAVE_WAIT_STATES)
            state_q <= hbp_pkg::ST_SDONE;
        // slave cycle ends on the ready the host itself sees
        hbp_pkg::ST_SDONE:
          if (slave_ready_input_in)
            state_q <= hbp_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Slave wait counter
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      wait_q <= 2'h0;
    else if (advance)
      wait_q <= (state_q == hbp_pkg::ST_SWAIT) ? wait_q + 2'h1 : 2'h0;
  end

  // ==========================================================
  // Transfer bookkeeping
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      addr_q         <= '0;
      remain_q       <= '0;
      xfer_busy_out  <= 1'b0;
      xfer_error_out <= 1'b0;
      xfer_done_out  <= 1'b0;
    end
    else
    begin
      xfer_done_out <= 1'b0;
      if (xfer_start_in && !xfer_busy_out)
      begin
        addr_q         <= xfer_addr_in;
        remain_q       <= xfer_len_in;
        xfer_busy_out  <= 1'b1;
        // unaligned script fetch or empty transfer refused
        xfer_error_out <= (xfer_script_in && (xfer_addr_in[1:0] != 2'h0))
                          || (xfer_len_in == '0);
      end
      else if (xfer_error_out)
      begin
        xfer_busy_out  <= 1'b0;
        xfer_error_out <= 1'b0;
        xfer_done_out  <= 1'b1;
      end
      else if (advance && (state_q == hbp_pkg::ST_DATA) && slave_ready_input_in)
      begin
        addr_q   <= addr_q + {29'h0, beat_n};
        remain_q <= remain_q - {13'h0, beat_n};
        if (remain_q == {13'h0, beat_n})
        begin
          xfer_busy_out <= 1'b0;
          xfer_done_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Arbitration
  // request held across the tenure, dropped at burst end
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      bus_request_out           <= 1'b0;
      downstream_hold_grant_out <= 1'b0;
    end
    else
    begin
      if (advance && (state_q == hbp_pkg::ST_IDLE) && xfer_busy_out && !xfer_error_out
          && slave_sel_n_in)
        bus_request_out <= 1'b1;
      else if (xfer_done_out || !xfer_busy_out)
        bus_request_out <= 1'b0;
      // Lower chain members only see a grant we are not using
      downstream_hold_grant_out <= hold_grant_in && !xfer_busy_out
                                   && downstream_hold_request_in;
    end
  end

  // ==========================================================
  // Master outputs
  // address, lanes, direction loaded entering address_state; strobe lifts entering data_state
  // long-word address plus active-low lane enables
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      bus_addr_out            <= '0;
      byte_lane_enables_n_out <= hbp_pkg::BE_NONE_N;
      bus_write_out           <= 1'b0;
      addr_strobe_n_out       <= 1'b1;
      bus_ctl_oe_out          <= 1'b0;
      xfer_wdata_take_out     <= 1'b0;
    end
    else
    begin
      xfer_wdata_take_out <= 1'b0;
      if (advance && hold_grant_in && ((state_q == hbp_pkg::ST_REQ)
          || ((state_q == hbp_pkg::ST_DATA) && slave_ready_input_in
              && (remain_q != {13'h0, beat_n}))))
      begin
        bus_addr_out            <= (state_q == hbp_pkg::ST_REQ) ? addr_q[31:2]
                                   : 30'(addr_q[31:2] + 30'h1);
        byte_lane_enables_n_out <= (state_q == hbp_pkg::ST_REQ) ? ~beat_be
                                   : ~lane_mask(2'h0, (remain_q - {13'h0, beat_n} > 16'h4)
                                                ? 3'h4 : 3'(remain_q - {13'h0, beat_n}));
        bus_write_out           <= xfer_write_in;
        addr_strobe_n_out       <= 1'b0;
        bus_ctl_oe_out          <= 1'b1;
        xfer_wdata_take_out     <= xfer_write_in;
      end
      else if (advance && (state_q == hbp_pkg::ST_ADDR))
        addr_strobe_n_out <= 1'b1;
      else if (advance && (state_q == hbp_pkg::ST_DATA) && slave_ready_input_in)
      begin
        byte_lane_enables_n_out <= hbp_pkg::BE_NONE_N;
        addr_strobe_n_out       <= 1'b1;
        bus_ctl_oe_out          <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Data path and ready
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      bus_data_out             <= '0;
      bus_data_oe_out          <= 1'b0;
      ready_output_to_host_out <= 1'b0;
      reg_addr_out             <= '0;
      reg_wdata_out            <= '0;
      reg_be_out               <= '0;
      reg_we_out               <= 1'b0;
      xfer_rdata_out           <= '0;
      xfer_rbe_out             <= '0;
      xfer_rvalid_out          <= 1'b0;
    end
    else
    begin
      reg_we_out      <= 1'b0;
      xfer_rvalid_out <= 1'b0;
      if (xfer_wdata_take_out)
      begin
        bus_data_out    <= lane_gate(xfer_wdata_in, ~byte_lane_enables_n_out);
        bus_data_oe_out <= 1'b1;
      end
      // master read keeps only enabled lanes
      if (advance && (state_q == hbp_pkg::ST_DATA) && slave_ready_input_in)
      begin
        bus_data_oe_out <= 1'b0;
        if (!bus_write_out)
        begin
          xfer_rdata_out  <= lane_gate(bus_data_in, ~byte_lane_enables_n_out);
          xfer_rbe_out    <= ~byte_lane_enables_n_out;
          xfer_rvalid_out <= 1'b1;
        end
      end
      // ready output comes from a flop on the device clock
      // slave write latched on the edge that raises ready
      if (advance && (state_q == hbp_pkg::ST_SWAIT)
          && (wait_q == hbp_pkg::SLAVE_WAIT_STATES))
      begin
        ready_output_to_host_out <= 1'b1;
        reg_addr_out             <= slave_addr_in;
        reg_be_out               <= ~slave_be_n_in;
        reg_wdata_out            <= lane_gate(bus_data_in, ~slave_be_n_in);
        reg_we_out               <= slave_write_in;
        bus_data_out             <= lane_gate(reg_rdata_in, ~slave_be_n_in);
        bus_data_oe_out          <= !slave_write_in;
      end
      else if (advance && (state_q == hbp_pkg::ST_SDONE) && slave_ready_input_in)
      begin
        ready_output_to_host_out <= 1'b0;
        bus_data_oe_out          <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence grant_seen_s;
    (state_q == hbp_pkg::ST_REQ) && advance && hold_grant_in;
  endsequence

  sequence slave_end_s;
    advance && (state_q == hbp_pkg::ST_SWAIT) && (wait_q == hbp_pkg::SLAVE_WAIT_STATES);
  endsequence

  no_drive_ungranted_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (state_q == hbp_pkg::ST_REQ) |-> !bus_ctl_oe_out)
    else $error("control driven before grant");

  grant_to_addr_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    grant_seen_s |=> (state_q == hbp_pkg::ST_ADDR) && !addr_strobe_n_out ##2 (state_q == hbp_pkg::ST_DATA))
    else $error("address_state not followed by data_state");

  hold_in_data_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (state_q == hbp_pkg::ST_DATA) && $past(state_q == hbp_pkg::ST_DATA)
    |-> $stable(bus_addr_out) && $stable(byte_lane_enables_n_out))
    else $error("master outputs moved in data_state");

  wait_on_ready_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (state_q == hbp_pkg::ST_DATA) && advance && !slave_ready_input_in
    |=> (state_q == hbp_pkg::ST_DATA))
    else $error("left data_state without ready");

  slave_ready_time_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (state_q == hbp_pkg::ST_IDLE) ##1 (state_q == hbp_pkg::ST_SWAIT) |-> ##6 ready_output_to_host_out)
    else $error("slave wait count wrong");

  latch_with_ready_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    slave_end_s |=> ready_output_to_host_out && (reg_we_out == $past(slave_write_in)))
    else $error("slave write not latched with ready");

  phase_toggle_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    advance |=> phase_one ##1 !phase_one)
    else $error("phase not half rate");

  phase_start_a: assert property (@(posedge core_clk_in)
    $rose(reset_n_in) |-> !phase_one ##1 !phase_one ##1 !phase_one ##1 phase_one)
    else $error("phase one not on third edge");

  lane_gate_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    xfer_rvalid_out |-> ((xfer_rdata_out & ~lane_gate(32'hffffffff, xfer_rbe_out)) == 32'h0))
    else $error("disabled lane data passed");

  release_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(xfer_done_out) && !$past(xfer_error_out) |=> !bus_request_out && !bus_ctl_oe_out)
    else $error("bus kept after burst");

endmodule // hbp_port

// [core/hbp_pkg.sv]
package hbp_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned LANES      = 4;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned LEN_W      = 16;
  localparam int unsigned SREG_W     = 8;

  // ==========================================================
  // Reset and phase alignment
  localparam int unsigned RESET_MIN_EDGES  = 5;
  localparam int unsigned PHASE_START_EDGE = 3;
  localparam logic [1:0]  PHASE_CNT_LAST   = 2'(PHASE_START_EDGE - 1);

  // ==========================================================
  // Fixed slave wait states, counted in data_state repeats
  localparam logic [1:0]  SLAVE_WAIT_STATES = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [3:0]  BE_NONE_N = 4'hf;

  // ==========================================================
  // Bus state machine, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_REQ   = 6'h02,
    ST_ADDR  = 6'h04,
    ST_DATA  = 6'h08,
    ST_SWAIT = 6'h10,
    ST_SDONE = 6'h20
  } hbp_state_t;

endpackage

// [core/hbp_phase_gen.sv]
`timescale 1ns/1ps

// Divides the double-rate clock into two phases, aligned from reset
module hbp_phase_gen (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  // Phase outputs
  output logic      phase_one_out,
  output logic      advance_out
);

  logic [1:0] cnt_q;
  logic       started_q;

  // ==========================================================
  // Alignment counter
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q     <= 2'h0;
      started_q <= 1'b0;
    end
    else if (!started_q)
    begin
      cnt_q     <= cnt_q + 2'h1;
      started_q <= (cnt_q == hbp_pkg::PHASE_CNT_LAST);
    end
  end

  // ==========================================================
  // Phase flop
  // third edge starts phase one
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      phase_one_out <= 1'b0;
    else if (started_q)
      phase_one_out <= ~phase_one_out;
    else
      phase_one_out <= (cnt_q == hbp_pkg::PHASE_CNT_LAST);
  end

  // True in the cycle whose closing edge opens a new phase one
  assign advance_out = started_q ? ~phase_one_out : (cnt_q == hbp_pkg::PHASE_CNT_LAST);

endmodule // hbp_phase_gen

// [sim/hbp_host_model.sv]
`timescale 1ns/1ps

// Host processor and memory facing the port
module hbp_host_model (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // Device bus signals
  input  wire logic              bus_request_in,
  input  wire logic [29:0]       addr_in,
  input  wire logic [3:0]        be_n_in,
  input  wire logic              write_in,
  input  wire logic              strobe_n_in,
  input  wire logic              ctl_oe_in,
  input  wire logic              data_oe_in,
  input  wire logic [31:0]       dev_data_in,
  input  wire logic              ready_to_host_in,
  // Host stimulus
  input  wire logic [31:0]       host_data_in,
  input  wire logic [3:0]        wait_max_in,
  // Answers
  output logic                   hold_grant_out,
  output logic                   slave_ready_out,
  output logic [31:0]            bus_data_out,
  output logic                   phase_ref_out
);
  logic [3:0]  grant_cnt_q;
  logic [3:0]  wait_cnt_q;
  logic        ready_q;
  logic [31:0] noise_q;
  logic [31:0] lane_mask;

  // Grant after a random delay of 0 to 3 clocks while requested
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in || !bus_request_in)
    begin
      hold_grant_out <= 1'b0;
      grant_cnt_q    <= 4'($urandom_range(3, 0));
    end
    else if (grant_cnt_q == 4'h0)
      hold_grant_out <= 1'b1;
    else
      grant_cnt_q <= grant_cnt_q - 4'h1;
  end

  // Slave ready after a random number of wait states
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in || !ctl_oe_in || !strobe_n_in)
    begin
      ready_q    <= 1'b0;
      wait_cnt_q <= 4'($urandom_range(32'(wait_max_in), 0));
    end
    else if (wait_cnt_q == 4'h0)
      ready_q <= 1'b1;
    else
      wait_cnt_q <= wait_cnt_q - 4'h1;
  end

  // Phase reference rebuilt from clock and reset
  always_ff @(posedge clk_in)
  begin
    noise_q       <= reset_n_in ? noise_q * 32'h0019660d + 32'h3c6ef35f : 32'h1;
    phase_ref_out <= reset_n_in ? ~phase_ref_out : 1'b0;
  end

  // Device sees exactly the ready the host sees
  assign slave_ready_out = ctl_oe_in ? ready_q : ready_to_host_in;
  assign lane_mask = {{8{~be_n_in[3]}}, {8{~be_n_in[2]}}, {8{~be_n_in[1]}}, {8{~be_n_in[0]}}};

  // Memory word per long-word address, noise on disabled lanes
  always_comb
  begin
    if (data_oe_in)
      bus_data_out = dev_data_in;
    else if (ctl_oe_in && !write_in && strobe_n_in)
      bus_data_out = (({addr_in, 2'h0} ^ 32'h5a3c96e1) & lane_mask) | (noise_q & ~lane_mask);
    else if (!ctl_oe_in)
      bus_data_out = host_data_in;
    else
      bus_data_out = noise_q;
  end
endmodule // hbp_host_model

// [sim/tb_host_bus_master_slave_port.sv]
`timescale 1ns/1ps

module tb_host_bus_master_slave_port;
  logic        clk = 1'b0;
  logic        rst_src_n = 1'b0;
  logic [1:0]  rst_sync_q = 2'h0;
  logic        rst_n, bus_req, grant, ds_grant, wr, strobe_n, ctl_oe, data_oe, slv_ready;
  logic        rdy_host, reg_we, busy, err, take, rvalid, done, phase_ref;
  logic        prev_oe, prev_stb_n, prev_rdy;
  logic [29:0] addr, prev_addr;
  logic [3:0]  be_n, prev_be_n, reg_be, rbe;
  logic [31:0] d_to_dut, d_from_dut, reg_wdata, reg_rdata, rdata;
  logic [5:0]  reg_addr;
  logic        sel_n = 1'b1, s_wr = 1'b0, x_start = 1'b0, x_wr = 1'b0, x_script = 1'b0;
  logic [5:0]  s_addr = 6'h0;
  logic [3:0]  s_be_n = 4'hf, wait_max = 4'h0;
  logic [31:0] x_addr = 32'h0, x_wdata = 32'h0, host_data = 32'h0;
  logic [15:0] x_len = 16'h0;
  logic [35:0] exp_q[$], got_q[$];
  logic [31:0] rd_q[$];
  logic [3:0]  rbe_q[$];
  int          n_fail = 0, n_compared = 0, cnt = 0, req_cnt;

  always #4 clk = ~clk;
  // Reset passes two flops before the port
  always @(posedge clk) rst_sync_q <= {rst_sync_q[0], rst_src_n};
  always @(posedge clk) cnt <= rst_n ? cnt + 1 : 0;
  assign rst_n = rst_sync_q[1];
  assign reg_rdata = {4{2'h0, s_addr}} ^ 32'hc3a51e69;

  hbp_port dut (.core_clk_in(clk), .reset_n_in(rst_n), .bus_request_out(bus_req),
    .hold_grant_in(grant), .downstream_hold_request_in(1'b0), .downstream_hold_grant_out(ds_grant),
    .bus_addr_out(addr), .byte_lane_enables_n_out(be_n), .bus_write_out(wr),
    .addr_strobe_n_out(strobe_n), .bus_ctl_oe_out(ctl_oe), .bus_data_in(d_to_dut),
    .bus_data_out(d_from_dut), .bus_data_oe_out(data_oe), .slave_ready_input_in(slv_ready),
    .ready_output_to_host_out(rdy_host), .slave_sel_n_in(sel_n), .slave_write_in(s_wr),
    .slave_addr_in(s_addr), .slave_be_n_in(s_be_n), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_be_out(reg_be), .reg_we_out(reg_we), .reg_rdata_in(reg_rdata),
    .xfer_start_in(x_start), .xfer_write_in(x_wr), .xfer_script_in(x_script),
    .xfer_addr_in(x_addr), .xfer_len_in(x_len), .xfer_wdata_in(x_wdata), .xfer_busy_out(busy),
    .xfer_error_out(err), .xfer_wdata_take_out(take), .xfer_rdata_out(rdata),
    .xfer_rbe_out(rbe), .xfer_rvalid_out(rvalid), .xfer_done_out(done));

  hbp_host_model host (.clk_in(clk), .reset_n_in(rst_n), .bus_request_in(bus_req),
    .addr_in(addr), .be_n_in(be_n), .write_in(wr), .strobe_n_in(strobe_n), .ctl_oe_in(ctl_oe),
    .data_oe_in(data_oe), .dev_data_in(d_from_dut), .ready_to_host_in(rdy_host),
    .host_data_in(host_data), .wait_max_in(wait_max), .hold_grant_out(grant),
    .slave_ready_out(slv_ready), .bus_data_out(d_to_dut), .phase_ref_out(phase_ref));

  function automatic logic [31:0] lanes(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({35'h0, got}, {35'h0, exp});
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // Bus watcher
  always @(negedge clk)
  begin
    if (rst_n && ctl_oe)
    begin
      cmp_flag(grant & bus_req, 1'b1);
      if (prev_oe && prev_stb_n && strobe_n && !prev_rdy)
        cmp_word(36'({addr, be_n, wr}), 36'({prev_addr, prev_be_n, x_wr}));
      if (!strobe_n && (!prev_oe || prev_stb_n))
      begin
        got_q.push_back({2'h0, addr, be_n});
        cmp_flag(phase_ref, 1'b1);
      end
      if (wr && strobe_n && slv_ready)
        cmp_word(36'({data_oe, d_from_dut & lanes(~be_n)}), 36'({1'b1, x_wdata & lanes(~be_n)}));
    end
    if (rvalid === 1'b1)
    begin
      rd_q.push_back(rdata);
      rbe_q.push_back(rbe);
    end
    prev_oe    <= ctl_oe;
    prev_stb_n <= strobe_n;
    prev_rdy   <= slv_ready;
    prev_addr  <= addr;
    prev_be_n  <= be_n;
  end

  // ==========================================================
  // Master transfer with expected beat list
  task automatic do_xfer(input logic w, input logic scr, input logic [31:0] a, input int len);
    logic [31:0] p;
    logic [3:0]  m;
    int          rem, n, k;
    p = a;
    rem = len;
    // Refused fetches move nothing on the bus
    if (scr && (a[1:0] != 2'h0))
      rem = 0;
    exp_q.delete();
    got_q.delete();
    rd_q.delete();
    rbe_q.delete();
    while (rem > 0)
    begin
      n = (4 - p[1:0] > rem) ? rem : 4 - p[1:0];
      m = 4'((1 << n) - 1) << p[1:0];
      exp_q.push_back({2'h0, p[31:2], ~m});
      p = p + 32'(n);
      rem -= n;
    end
    x_wr = w;
    x_script = scr;
    x_addr = a;
    x_len = 16'(len);
    x_wdata = $urandom();
    x_start = 1'b1;
    tick();
    x_start = 1'b0;
    req_cnt = 0;
    for (k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      if (bus_req === 1'b1 && req_cnt == 0)
        req_cnt = cnt;
      tick();
    end
    // Request drops one clock after the done pulse
    tick();
    cmp_flag(bus_req | ctl_oe, 1'b0);
    cmp_flag(ds_grant, 1'b0);
    cmp_word(36'(got_q.size()), 36'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        cmp_word(got_q[i], exp_q[i]);
    if (!w)
      cmp_word(36'(rd_q.size()), 36'(exp_q.size()));
    foreach (rd_q[i])
      if (!w && i < exp_q.size())
      begin
        m = ~exp_q[i][3:0];
        cmp_word(36'({rbe_q[i], rd_q[i] & lanes(m)}),
                 36'({m, ({exp_q[i][33:4], 2'h0} ^ 32'h5a3c96e1) & lanes(m)}));
      end
    x_script = 1'b0;
  endtask

  task automatic slave_op(input logic w, input logic [5:0] a, input logic [3:0] ben);
    logic [31:0] m;
    int          n;
    m = lanes(~ben);
    while (cnt % 2 != 0)
      tick();
    sel_n = 1'b0;
    s_wr = w;
    s_addr = a;
    s_be_n = ben;
    host_data = $urandom();
    n = 0;
    for (n = 0; n < 40 && rdy_host !== 1'b1; n++)
      tick();
    // Taken at the next advance edge, then a fixed count of advances
    cmp_word(36'(n), 36'(1 + 2 * (hbp_pkg::SLAVE_WAIT_STATES + 1)));
    if (w)
    begin
      cmp_word(36'({reg_we, reg_be, reg_addr}), 36'({1'b1, ~ben, a}));
      cmp_word(36'(reg_wdata & m), 36'(host_data & m));
    end
    else
      cmp_word(36'({data_oe, d_from_dut & m}), 36'({1'b1, reg_rdata & m}));
    for (n = 0; n < 40 && rdy_host === 1'b1; n++)
      tick();
    cmp_flag(rdy_host, 1'b0);
    sel_n = 1'b1;
    repeat (3) tick();
  endtask

  initial
  begin
    #800000;
    n_fail++;
    close_out();
  end

  initial
  begin
    void'($urandom(39429));
    repeat (hbp_pkg::RESET_MIN_EDGES + 1) @(posedge clk);
    #1;
    cmp_word(36'({bus_req, ctl_oe, data_oe, rdy_host, be_n, strobe_n}), 36'({4'h0, 4'hf, 1'b1}));
    rst_src_n = 1'b1;
    while (rst_n !== 1'b1)
      tick();
    do_xfer(1'b0, 1'b0, 32'h100, 4);
    cmp_word(36'(req_cnt), 36'(hbp_pkg::PHASE_START_EDGE));
    do_xfer(1'b1, 1'b0, 32'h203, 1);
    do_xfer(1'b0, 1'b1, 32'h400, 12);
    wait_max = 4'hc;
    do_xfer(1'b0, 1'b0, 32'h501, 10);
    do_xfer(1'b1, 1'b0, 32'h702, 7);
    for (int i = 0; i < 4; i++)
    begin
      x_script = 1'b1;
      do_xfer(1'b0, 1'b1, 32'h600 | 32'(i), (i == 0) ? 0 : 4);
      cmp_word(36'(got_q.size()), 36'h0);
    end
    slave_op(1'b1, 6'h05, 4'h0);
    slave_op(1'b1, 6'h2a, 4'ha);
    slave_op(1'b0, 6'h11, 4'h3);
    for (int i = 0; i < 16; i++)
    begin
      wait_max = 4'($urandom_range(5, 0));
      do_xfer(1'($urandom()), 1'b0, $urandom() & 32'hffff, 1 + $urandom_range(23, 0));
      if (i % 4 == 3)
        slave_op(1'($urandom()), 6'($urandom()), 4'($urandom()));
    end
    close_out();
  end
endmodule // tb_host_bus_master_slave_port
